// File: fpt_defines.svh
`ifndef FPT_DEFINES_SVH
`define FPT_DEFINES_SVH

// register byte offsets
`define FPT_OFF_ADDR 12'h000
`define FPT_OFF_DATA 12'h004
`define FPT_OFF_CTRL 12'h008
`define FPT_OFF_RIS 12'h00c
`define FPT_OFF_IMASK 12'h010
`define FPT_OFF_MISC 12'h014
`define FPT_OFF_USEC 12'h140
`define FPT_OFF_RE_BASE 12'h200
`define FPT_OFF_PE_BASE 12'h400

// control register fields
`define FPT_KEY 16'ha442
`define FPT_CTRL_WRITE 0
`define FPT_CTRL_ERASE 1
`define FPT_CTRL_MERASE 2
`define FPT_CTRL_COMMIT 3

// interrupt bits
`define FPT_INT_ACCESS 0
`define FPT_INT_READ 1
`define FPT_INT_DONE 2

// reset values
`define FPT_USEC_RESET 8'h31
`define FPT_PROT_RESET 32'hffffffff

// timing: program, erase and commit times in microseconds
`define FPT_PROG_US 16'h0014
`define FPT_ERASE_US 16'h0020
`define FPT_COMMIT_US 16'h0010

// array geometry
`define FPT_WORDS_PER_PAGE 256
`define FPT_PAGE_LSB 8
`define FPT_BLOCK_LSB 9

`endif

// File: fpt_pkg.sv
package fpt_pkg;

	typedef enum logic [2:0] {
		FPT_IDLE,
		FPT_PROG,
		FPT_ERASE,
		FPT_MERASE,
		FPT_COMMIT
	} fpt_op_t;

	// apb request as seen by the slave
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} fpt_apb_req_t;

	// instruction or data read port of the array
	typedef struct packed {
		logic valid;
		logic is_fetch;
		logic [16:0] word_addr;
	} fpt_rd_req_t;

endpackage : fpt_pkg

// File: fpt_flash_ctrl.sv
// Function
// - erase sets a whole 1 KB page to ones
// - program ANDs one 32-bit word into array
// - protection granule is two 1 KB pages
// - locked block serves instruction fetch only
// - op timing counts from cycles_per_us_reload
// - one program and read bit per block
// - program-enable zero blocks program and erase
// - read-enable zero refuses data reads
// - pe one re zero: write not read
// - both ones: fully open block
// - protected modify blocked, flags masked interrupt
// - protected data read returns zeros, flags
// - protection bits reset to ones
// - protection writes volatile until committed (here reset loads ones even after a commit)
// - uncommitted clears restored by power-on reset
// - software can only clear protection bits
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "fpt_defines.svh"

module fpt_flash_ctrl
	import fpt_pkg::*;
#(
	parameter int WORDS = 32768,
	parameter int NREGS = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire fpt_apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire fpt_rd_req_t rd_req,
	output logic [31:0] rd_data,
	output logic rd_valid,
	output logic rd_refused,
	output logic irq
);

	localparam int NBLK = NREGS * 32;
	localparam int AW = $clog2(WORDS);

	typedef struct packed {
		fpt_op_t op;
		logic [AW-1:0] addr;
		logic [31:0] wdata;
		logic [7:0] usec;
		logic [7:0] us_cnt;
		logic [15:0] us_left;
		logic [8:0] page_idx;
		logic [2:0] ris;
		logic [2:0] imask;
		logic [NBLK-1:0] re;
		logic [NBLK-1:0] pe;
		logic [NBLK-1:0] re_nv;
		logic [NBLK-1:0] pe_nv;
		logic [31:0] prdata;
		logic [31:0] rd_data;
		logic rd_valid;
		logic rd_refused;
		logic rd_wait;
	} fpt_state_t;

	fpt_state_t st;
	fpt_state_t next_st;
	logic [31:0] mem [WORDS];
	logic mem_we;
	logic [AW-1:0] mem_waddr;
	logic [31:0] mem_wdata;

	wire logic wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite;
	wire logic rd_acc = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
	wire logic [11:0] off = apb_req.paddr;
	wire logic [AW-1:0] rd_word = rd_req.word_addr[AW-1:0];
	wire logic [AW-1-`FPT_BLOCK_LSB:0] op_blk =
		st.addr[AW-1:`FPT_BLOCK_LSB];
	wire logic [AW-1-`FPT_BLOCK_LSB:0] rd_blk = rd_word[AW-1:`FPT_BLOCK_LSB];

	// reads take one wait state so prdata comes from a flip-flop
	assign pready = ~rd_acc | st.rd_wait;
	assign pslverr = 1'b0;
	assign prdata = st.prdata;
	assign rd_data = st.rd_data;
	assign rd_valid = st.rd_valid;
	assign rd_refused = st.rd_refused;
	assign irq = |(st.ris & st.imask);

	// array: program ands in, erase writes ones
	always_ff @(posedge pclk) begin
		if (mem_we) begin
			mem[mem_waddr] <= mem_wdata;
		end
	end

	// operation sequencer, protection and register file
	always_comb begin
		logic [31:0] rv;
		logic done_us;
		next_st = st;
		rv = 32'h0;
		done_us = 1'b0;
		mem_we = 1'b0;
		mem_waddr = st.addr;
		mem_wdata = 32'h0;
		next_st.rd_valid = 1'b0;
		next_st.rd_refused = 1'b0;
		next_st.rd_wait = rd_acc & ~st.rd_wait;

		// write-one-to-clear first, so a set in the same cycle wins
		if (wr_acc && off == `FPT_OFF_MISC) begin
			next_st.ris = st.ris & ~apb_req.pwdata[2:0];
		end

		// microsecond tick from the reload value
		if (st.op != FPT_IDLE) begin
			if (st.us_cnt == 8'h00) begin
				next_st.us_cnt = st.usec;
				if (st.us_left != 16'h0000) begin
					next_st.us_left = st.us_left - 16'h0001;
				end else begin
					done_us = 1'b1;
				end
			end else begin
				next_st.us_cnt = st.us_cnt - 8'h01;
			end
		end

		case (st.op)
		FPT_IDLE: begin
		end
		FPT_PROG: begin
			if (done_us) begin
				mem_we = 1'b1;
				mem_wdata = mem[st.addr] & st.wdata;
				next_st.op = FPT_IDLE;
				next_st.ris[`FPT_INT_DONE] = 1'b1;
			end
		end
		FPT_ERASE, FPT_MERASE: begin
			if (done_us) begin
				mem_we = 1'b1;
				mem_wdata = 32'hffffffff;
				mem_waddr = st.addr + AW'(st.page_idx);
				if (st.page_idx == 9'(`FPT_WORDS_PER_PAGE - 1) &&
					(st.op == FPT_ERASE ||
					st.addr >= AW'(WORDS - `FPT_WORDS_PER_PAGE))) begin
					next_st.op = FPT_IDLE;
					next_st.ris[`FPT_INT_DONE] = 1'b1;
				end else if (st.page_idx == 9'(`FPT_WORDS_PER_PAGE - 1)) begin
					next_st.addr = st.addr + AW'(`FPT_WORDS_PER_PAGE);
					next_st.page_idx = 9'h000;
				end else begin
					next_st.page_idx = st.page_idx + 9'h001;
				end
				next_st.us_left = 16'h0000;
			end
		end
		FPT_COMMIT: begin
			if (done_us) begin
				next_st.re_nv = st.re;
				next_st.pe_nv = st.pe;
				next_st.op = FPT_IDLE;
				next_st.ris[`FPT_INT_DONE] = 1'b1;
			end
		end
		default: next_st.op = FPT_IDLE;
		endcase

		// array read port: data reads honour read-enable
		if (rd_req.valid) begin
			if (!rd_req.is_fetch && !st.re[rd_blk]) begin
				next_st.rd_refused = 1'b1;
				next_st.ris[`FPT_INT_READ] = 1'b1;
			end
		end
		next_st.rd_valid = rd_req.valid;
		next_st.rd_data = 32'h0;
		if (rd_req.valid && !next_st.rd_refused) begin
			next_st.rd_data = mem[rd_word];
		end

		// register writes
		if (wr_acc) begin
			case (off)
			`FPT_OFF_ADDR: next_st.addr = apb_req.pwdata[AW+1:2];
			`FPT_OFF_DATA: next_st.wdata = apb_req.pwdata;
			`FPT_OFF_USEC: next_st.usec = apb_req.pwdata[7:0];
			`FPT_OFF_IMASK: next_st.imask = apb_req.pwdata[2:0];
			`FPT_OFF_CTRL: begin
				if (apb_req.pwdata[31:16] == `FPT_KEY &&
					st.op == FPT_IDLE) begin
					next_st.us_cnt = st.usec;
					next_st.page_idx = 9'h000;
					if (apb_req.pwdata[`FPT_CTRL_COMMIT]) begin
						next_st.op = FPT_COMMIT;
						next_st.us_left = `FPT_COMMIT_US;
					end else if (apb_req.pwdata[`FPT_CTRL_MERASE]) begin
						if (&st.pe) begin
							next_st.op = FPT_MERASE;
							next_st.addr = '0;
							next_st.us_left = `FPT_ERASE_US;
						end else begin
							next_st.ris[`FPT_INT_ACCESS] = 1'b1;
						end
					end else if (apb_req.pwdata[`FPT_CTRL_ERASE] ||
						apb_req.pwdata[`FPT_CTRL_WRITE]) begin
						if (st.pe[op_blk]) begin
							if (apb_req.pwdata[`FPT_CTRL_ERASE]) begin
								next_st.op = FPT_ERASE;
								next_st.addr = {st.addr[AW-1:`FPT_PAGE_LSB],
									`FPT_PAGE_LSB'(0)};
								next_st.us_left = `FPT_ERASE_US;
							end else begin
								next_st.op = FPT_PROG;
								next_st.us_left = `FPT_PROG_US;
							end
						end else begin
							next_st.ris[`FPT_INT_ACCESS] = 1'b1;
						end
					end
				end
			end
			default: begin
			end
			endcase
		end

		// protection writes can only clear bits
		for (int i = 0; i < NREGS; i++) begin
			if (wr_acc && off == `FPT_OFF_RE_BASE + 12'(4 * i)) begin
				next_st.re[i*32 +: 32] = st.re[i*32 +: 32] &
					apb_req.pwdata;
			end
			if (wr_acc && off == `FPT_OFF_PE_BASE + 12'(4 * i)) begin
				next_st.pe[i*32 +: 32] = st.pe[i*32 +: 32] &
					apb_req.pwdata;
			end
		end

		// register reads
		case (off)
		`FPT_OFF_ADDR: rv = 32'({st.addr, 2'b00});
		`FPT_OFF_DATA: rv = st.wdata;
		`FPT_OFF_CTRL: rv = {28'h0, st.op == FPT_COMMIT,
			st.op == FPT_MERASE, st.op == FPT_ERASE, st.op == FPT_PROG};
		`FPT_OFF_RIS: rv = {29'h0, st.ris};
		`FPT_OFF_IMASK: rv = {29'h0, st.imask};
		`FPT_OFF_MISC: rv = {29'h0, st.ris & st.imask};
		`FPT_OFF_USEC: rv = {24'h0, st.usec};
		default: rv = 32'h0;
		endcase
		for (int i = 0; i < NREGS; i++) begin
			if (off == `FPT_OFF_RE_BASE + 12'(4 * i)) rv = st.re[i*32 +: 32];
			if (off == `FPT_OFF_PE_BASE + 12'(4 * i)) rv = st.pe[i*32 +: 32];
		end
		// capture in the first access cycle, hold through the wait state
		if (rd_acc && !st.rd_wait) begin
			next_st.prdata = rv;
		end
	end

	// state register; reset sets all protection bits to ones, committed or not
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.usec <= `FPT_USEC_RESET;
			st.re <= '1;
			st.pe <= '1;
			st.re_nv <= '1;
			st.pe_nv <= '1;
		end else begin
			st <= next_st;
		end
	end

endmodule : fpt_flash_ctrl

// File: fpt_flash_ctrl_chk.sv
`timescale 1ns/100ps
module fpt_flash_ctrl_chk
	import fpt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire fpt_apb_req_t apb_req,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire fpt_rd_req_t rd_req,
	input wire logic [31:0] rd_data,
	input wire logic rd_valid,
	input wire logic rd_refused,
	input wire logic irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// read port timing and refusal
	rd_answer_a: assert property (
		rd_req.valid |=> rd_valid) else $error("read not answered");
	rd_spur_a: assert property (
		!rd_req.valid |=> !rd_valid) else $error("answer without request");
	zero_fill_a: assert property (
		rd_refused |-> rd_data == 32'h0) else $error("refused read not zero");
	fetch_pass_a: assert property (
		rd_req.valid && rd_req.is_fetch |=> rd_valid && !rd_refused)
		else $error("fetch refused");
	data_only_a: assert property (
		rd_refused |-> $past(rd_req.valid && !rd_req.is_fetch))
		else $error("refusal of a fetch");
	// bus answer within one wait state
	bus_ready_a: assert property (
		apb_req.psel && apb_req.penable |-> ##[0:1] pready)
		else $error("bus answer late");
	bus_err_a: assert property (
		!pslverr) else $error("slave error");
	hole_read_a: assert property (
		apb_req.psel && apb_req.penable && !apb_req.pwrite
		&& apb_req.paddr == 12'h0f0 |=> prdata == 32'h0)
		else $error("hole not zero");
	cover property (rd_refused);
	cover property (rd_valid && !rd_refused);
	cover property (irq);
endmodule : fpt_flash_ctrl_chk

bind fpt_flash_ctrl fpt_flash_ctrl_chk u_chk (.pclk(pclk),
	.presetn(presetn), .apb_req(apb_req), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .rd_req(rd_req),
	.rd_data(rd_data), .rd_valid(rd_valid), .rd_refused(rd_refused),
	.irq(irq));

// File: fpt_cpu_model.sv
`timescale 1ns/100ps
module fpt_cpu_model
	import fpt_pkg::*;
(
	input wire logic pclk,
	output fpt_rd_req_t rd_req
);
	initial rd_req = '0;
	// one-cycle read; address lines flip once released
	task automatic rd(input logic f, input logic [16:0] a);
		rd_req <= '{1'b1, f, a};
		@(posedge pclk);
		rd_req <= '{1'b0, f, ~a};
	endtask : rd
endmodule : fpt_cpu_model

// File: fpt_flash_ctrl_tb_top.sv
`timescale 1ns/100ps
`include "fpt_defines.svh"
module fpt_flash_ctrl_tb_top
	import fpt_pkg::*;
;
	logic pclk = 0, presetn = 0, tk = 0;
	fpt_apb_req_t req = '0;
	fpt_rd_req_t rq;
	logic [31:0] prdata, rd_data, r, bm, d, e2;
	logic pready, pslverr, rd_valid, rd_refused, irq;
	logic [11:0] re, pe;
	logic [32:0] q[$];
	int mismatches = 0, n_tests = 0, n, k;
	fpt_flash_ctrl DUT (.pclk(pclk), .presetn(presetn), .apb_req(req),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rd_req(rq), .rd_data(rd_data), .rd_valid(rd_valid),
		.rd_refused(rd_refused), .irq(irq));
	fpt_cpu_model u_cpu (.pclk(pclk), .rd_req(rq));
	initial forever #10 pclk = ~pclk;
	task automatic summarize();
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	task automatic check(input logic [32:0] g, input logic [32:0] e);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask : check
	// setup, access until pready, take read data, then release
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready) break;
		end
		if (k == 20) begin
			mismatches++;
			summarize();
		end
		r = prdata;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rx(input logic [11:0] a, input logic [31:0] e);
		q.push_back({1'b0, e});
		apb(1'b0, a, 32'h0);
	endtask : rx
	task automatic dx(input logic f, input logic [16:0] a, input logic e,
		input logic [31:0] x);
		q.push_back({e, x});
		u_cpu.rd(f, a);
		@(posedge pclk);
	endtask : dx
	// poll control until the operation bits clear
	task automatic wt();
		for (int i = 0; i < 1000; i++) begin
			apb(1'b0, `FPT_OFF_CTRL, 32'h0);
			if (r[3:0] == 4'h0) break;
			if (i == 999) begin
				mismatches++;
				summarize();
			end
		end
		@(posedge pclk);
	endtask : wt
	// monitor: oldest note against each answer
	always @(posedge pclk) begin
		if (tk && q.size() > 0) check({1'b0, prdata}, q.pop_front());
		if (rd_valid && q.size() > 0)
			check({rd_refused, rd_data}, q.pop_front());
		tk <= req.psel && req.penable && !req.pwrite && pready;
	end
	initial begin
		void'($urandom(5));
		n = $urandom % 64;
		re = `FPT_OFF_RE_BASE + 12'(4 * (n / 32));
		pe = `FPT_OFF_PE_BASE + 12'(4 * (n / 32));
		bm = ~(32'h1 << (n % 32));
		d = $urandom;
		e2 = $urandom;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rx(`FPT_OFF_USEC, 32'h31);
		rx(re, 32'hffffffff);
		rx(pe, 32'hffffffff);
		rx(12'h0f0, 32'h0);
		apb(1'b1, `FPT_OFF_USEC, 32'h3);
		// erase the first page of both blocks, then program twice
		apb(1'b1, `FPT_OFF_ADDR, 32'(n << 11));
		apb(1'b1, `FPT_OFF_CTRL, 32'ha4420002);
		wt();
		apb(1'b1, `FPT_OFF_ADDR, 32'((n ^ 1) << 11));
		apb(1'b1, `FPT_OFF_CTRL, 32'ha4420002);
		wt();
		apb(1'b1, `FPT_OFF_DATA, d);
		apb(1'b1, `FPT_OFF_CTRL, 32'ha4420001);
		wt();
		apb(1'b1, `FPT_OFF_DATA, e2);
		apb(1'b1, `FPT_OFF_CTRL, 32'ha4420001);
		wt();
		dx(1'b0, 17'((n ^ 1) << 9), 1'b0, d & e2);
		dx(1'b0, 17'(((n ^ 1) << 9) + 1), 1'b0, 32'hffffffff);
		apb(1'b1, re, bm);
		rx(re, bm);
		dx(1'b0, 17'(n << 9), 1'b1, 32'h0);
		dx(1'b1, 17'(n << 9), 1'b0, 32'hffffffff);
		dx(1'b0, 17'((n ^ 1) << 9), 1'b0, d & e2);
		apb(1'b1, re, 32'hffffffff);
		rx(re, bm);
		apb(1'b1, `FPT_OFF_IMASK, 32'h1);
		check({32'h0, irq}, 33'h0);
		// program attempt on a program-protected block is refused
		apb(1'b1, pe, bm);
		apb(1'b1, `FPT_OFF_ADDR, 32'(n << 11));
		apb(1'b1, `FPT_OFF_DATA, 32'h0);
		apb(1'b1, `FPT_OFF_CTRL, 32'ha4420001);
		wt();
		check({32'h0, irq}, 33'h1);
		dx(1'b1, 17'(n << 9), 1'b0, 32'hffffffff);
		rx(`FPT_OFF_MISC, 32'h1);
		apb(1'b1, `FPT_OFF_MISC, 32'h1);
		check({32'h0, irq}, 33'h0);
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rx(re, 32'hffffffff);
		apb(1'b1, `FPT_OFF_CTRL, 32'ha4420008);
		wt();
		rx(pe, 32'hffffffff);
		summarize();
	end
endmodule : fpt_flash_ctrl_tb_top
